// file: logic/safr_regs_top.v
// Function
// - averaging field selects none to 128 samples
// - one output word per N samples
// - bit 13 bypasses pressure correction, raw out
// - pressure bypass: only pressure conversions
// - bit 14 bypasses temperature correction, raw out
// - temperature bypass: only temperature conversions, unless bit 13 is also set
// - bit 15 set disables calibration memory
// - every anomaly flagged; enabled ones assert alert
// - bits 8, 9 flag new results
// - fault bits 11, 10 always alert
// - drive fault: over 4.25V or imbalance
// - thermistor fault on above-2V comparator
// - writing one clears that flag only
// - upper four bits (15:12) of flag write ignored
// - gain bits 5:0, bits 7:6 reserved
// - three-bit current code decoded to microamps
// - raw pressure register, 16-bit two's complement
// - raw temperature register, 16-bit signed
// - bit 7 shutdown, serial still accepted
// - interrupt enable mirrors flags 9:0, resets ones
// - interrupts only in alert mode 000
`include "safr_regs.vh"
`default_nettype none
module safr_regs_top (
  input wire core_clk_i,
  input wire nrst_i,
  input wire ce_i,
  // register port from the serial interface decoder
  input wire [7:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  output reg reg_rvalid_o,
  // converter samples, same clock
  input wire adc_valid_i,
  input wire adc_is_temp_i,
  input wire [15:0] adc_data_i,
  // asynchronous comparator levels
  input wire [7:0] pin_limit_cmp_i,
  input wire drive_over_limit_i,
  input wire bridge_imbalance_i,
  input wire thermistor_over_limit_i,
  // control outputs
  // all of them registered, one cycle behind the register contents
  output reg alert_n_o,
  output reg shutdown_o,
  output reg cal_memory_access_enable_o,
  output reg allow_pressure_conv_o,
  output reg allow_temp_conv_o,
  output reg [1:0] analog_out_src_o,
  output reg [7:0] avg_samples_o,
  output reg [5:0] front_end_amplifier_gain_o,
  output reg gain_code_valid_o,
  output reg [9:0] bridge_current_ua_o,
  output reg result_valid_o,
  output reg result_is_temp_o,
  output reg [15:0] result_data_o
);
  // =====================================================================
  // storage
  // narrow registers keep only their defined bits; reads pad with zeros
  reg [15:0] configuration;
  reg [`SAFR_FLG_W-1:0] fault_and_ready_flags;
  reg [5:0] pressure_gain_select;
  reg [2:0] bridge_current_select;
  reg [`SAFR_IEN_W-1:0] irq_enable;
  reg [15:0] raw_pressure_result;
  reg [15:0] raw_temperature_result;
  wire [10:0] sync_b;
  reg [15:0] next_rdata;
  reg [9:0] next_current_ua;
  reg [`SAFR_FLG_W-1:0] next_flags;
  reg [2:0] avg_log2n;
  wire [10:0] async_in;
  wire [`SAFR_FLG_W-1:0] flag_events;
  wire [`SAFR_FLG_W-1:0] flag_clear;
  wire [1:0] avg_valid;
  wire [31:0] avg_data;
  // configuration fields
  wire [2:0] avg_code = configuration[`SAFR_CFG_AVG_HI:`SAFR_CFG_AVG_LO];
  wire [2:0] alert_mode =
    configuration[`SAFR_CFG_ALERT_MODE_HI:`SAFR_CFG_ALERT_MODE_LO];
  wire shut = configuration[`SAFR_CFG_SHUTDOWN];
  wire p_bypass = configuration[`SAFR_CFG_P_BYPASS];
  wire t_bypass = configuration[`SAFR_CFG_T_BYPASS];
  // scheduling: a bypass excludes the other channel, shutdown stops both
  // both bypass bits set: pressure-only mode wins
  wire p_allowed = !shut && !(t_bypass && !p_bypass);
  wire t_allowed = !shut && !p_bypass;
  // write strobes per register
  wire wr_cfg = reg_wr_i && (reg_addr_i == `SAFR_ADDR_CONFIG);
  wire wr_flags = reg_wr_i && (reg_addr_i == `SAFR_ADDR_FLAGS);
  wire alert_now;

  // =====================================================================
  // comparator synchronisers, two stages per bit
  assign async_in = {thermistor_over_limit_i, bridge_imbalance_i,
                     drive_over_limit_i, pin_limit_cmp_i};
  genvar gi;
  generate
    for (gi = 0; gi < 11; gi = gi + 1) begin : g_sync
      reg stage_a;
      reg stage_b;
      // only stage_b leaves the loop; stage_a may still be settling
      always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          stage_a <= 1'b0;
          stage_b <= 1'b0;
        end else if (ce_i) begin
          stage_a <= async_in[gi];
          stage_b <= stage_a;
        end
      end
      assign sync_b[gi] = stage_b;
    end
  endgenerate

  // =====================================================================
  // averaging depth decode: 000 none, 001..110 gives 4..128
  // the log2 value feeds both the averagers and the depth output
  always @* begin
    if (avg_code == 3'h0 || avg_code == 3'h7) begin
      avg_log2n = 3'h0; // 111 unused, treated as no averaging
    end else begin
      avg_log2n = avg_code + 3'h1;
    end
  end

  // =====================================================================
  // one averager per channel; samples gated by scheduling and shutdown
  // a configuration write drops any partial block, so a new depth
  // never mixes samples taken under the old one
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_avg
      safr_avg #(
        .W(16),
        .LMAX(7)
      ) u_avg (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .restart_i(wr_cfg),
        .log2n_i(avg_log2n),
        .in_valid_i(adc_valid_i && (adc_is_temp_i == (gi == 1))
                    && (gi == 0 ? p_allowed : t_allowed)),
        .in_data_i(adc_data_i),
        .out_valid_o(avg_valid[gi]),
        .out_data_o(avg_data[gi*16 +: 16])
      );
    end
  endgenerate

  // =====================================================================
  // flag sources; faults come from synchronised comparator levels
  // a standing level re-sets its flag every cycle, so a clear
  // only sticks once the pin has recovered
  assign flag_events[7:0] = sync_b[7:0];
  assign flag_events[`SAFR_FLG_P_READY] = avg_valid[0];
  assign flag_events[`SAFR_FLG_T_READY] = avg_valid[1];
  assign flag_events[`SAFR_FLG_THERM_FAULT] = sync_b[10];
  assign flag_events[`SAFR_FLG_DRIVE_FAULT] = sync_b[8] | sync_b[9];
  // only the low twelve bits matter, the upper four bits are ignored
  assign flag_clear = wr_flags ? reg_wdata_i[`SAFR_FLG_W-1:0] : {`SAFR_FLG_W{1'b0}};

  // sticky flags; a set in the clearing cycle wins over the clear
  always @* begin
    next_flags = (fault_and_ready_flags & ~flag_clear) | flag_events;
  end

  // =====================================================================
  // alert: unmaskable faults, masked flags only in interrupt mode
  // other mode codes belong to pin functions not built here; the two
  // faults still pull the pin so a broken bridge is never silent
  assign alert_now = fault_and_ready_flags[`SAFR_FLG_DRIVE_FAULT]
    | fault_and_ready_flags[`SAFR_FLG_THERM_FAULT]
    | ((alert_mode == `SAFR_ALERT_MODE_IRQ)
       && |(fault_and_ready_flags[`SAFR_IEN_W-1:0] & irq_enable));

  // =====================================================================
  // register writes
  // raw result registers have no write path, host writes there are dropped
  // flags update every enabled cycle so no event is lost during a write
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      configuration <= `SAFR_CONFIG_RST;
      fault_and_ready_flags <= {`SAFR_FLG_W{1'b0}};
      pressure_gain_select <= `SAFR_GAIN_RST;
      bridge_current_select <= `SAFR_CURRENT_RST;
      irq_enable <= `SAFR_IENABLE_RST;
      raw_pressure_result <= 16'h0000;
      raw_temperature_result <= 16'h0000;
    end else if (ce_i) begin
      fault_and_ready_flags <= next_flags;
      if (wr_cfg) begin
        configuration <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == `SAFR_ADDR_GAIN) begin
        pressure_gain_select <= reg_wdata_i[5:0];
      end
      if (reg_wr_i && reg_addr_i == `SAFR_ADDR_CURRENT) begin
        bridge_current_select <= reg_wdata_i[2:0];
      end
      if (reg_wr_i && reg_addr_i == `SAFR_ADDR_IENABLE) begin
        irq_enable <= reg_wdata_i[`SAFR_IEN_W-1:0];
      end
      // latest filtered converter words, two's complement kept as is
      if (avg_valid[0]) begin
        raw_pressure_result <= avg_data[15:0];
      end
      if (avg_valid[1]) begin
        raw_temperature_result <= avg_data[31:16];
      end
    end
  end

  // =====================================================================
  // read mux; reserved and unmapped bits read zero
  // data is captured only on a read strobe, so it stands until the next read
  always @* begin
    case (reg_addr_i)
      `SAFR_ADDR_CONFIG: next_rdata = configuration;
      `SAFR_ADDR_FLAGS: next_rdata = {4'h0, fault_and_ready_flags};
      `SAFR_ADDR_GAIN: next_rdata = {10'h000, pressure_gain_select};
      `SAFR_ADDR_CURRENT: next_rdata = {13'h0000, bridge_current_select};
      `SAFR_ADDR_IENABLE: next_rdata = {6'h00, irq_enable};
      `SAFR_ADDR_RAW_P: next_rdata = raw_pressure_result;
      `SAFR_ADDR_RAW_T: next_rdata = raw_temperature_result;
      default: next_rdata = 16'h0000;
    endcase
  end

  // =====================================================================
  // bridge current decode in microamps
  // code 111 is the only value left for the default branch
  always @* begin
    case (bridge_current_select)
      3'h0: next_current_ua = 10'd250;
      3'h1: next_current_ua = 10'd300;
      3'h2: next_current_ua = 10'd400;
      3'h3: next_current_ua = 10'd450;
      3'h4: next_current_ua = 10'd500;
      3'h5: next_current_ua = 10'd550;
      3'h6: next_current_ua = 10'd650;
      default: next_current_ua = 10'd750;
    endcase
  end

  // =====================================================================
  // registered outputs
  // reset values match the register defaults after decode
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 16'h0000;
      reg_rvalid_o <= 1'b0;
      alert_n_o <= 1'b1;
      shutdown_o <= 1'b0;
      cal_memory_access_enable_o <= 1'b1;
      allow_pressure_conv_o <= 1'b1;
      allow_temp_conv_o <= 1'b1;
      analog_out_src_o <= `SAFR_OUT_CAL;
      avg_samples_o <= 8'h01;
      front_end_amplifier_gain_o <= 6'h00;
      gain_code_valid_o <= 1'b1;
      bridge_current_ua_o <= 10'd250;
      result_valid_o <= 1'b0;
      result_is_temp_o <= 1'b0;
      result_data_o <= 16'h0000;
    end else if (ce_i) begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
      alert_n_o <= ~alert_now;
      shutdown_o <= shut;
      cal_memory_access_enable_o <= ~configuration[`SAFR_CFG_MEM_DISABLE];
      allow_pressure_conv_o <= p_allowed;
      allow_temp_conv_o <= t_allowed;
      // pressure bypass wins when both bypass bits are set
      if (p_bypass) begin
        analog_out_src_o <= `SAFR_OUT_RAW_P;
      end else if (t_bypass) begin
        analog_out_src_o <= `SAFR_OUT_RAW_T;
      end else begin
        analog_out_src_o <= `SAFR_OUT_CAL;
      end
      // samples per output word, one when filtering is off
      avg_samples_o <= 8'h01 << avg_log2n;
      front_end_amplifier_gain_o <= pressure_gain_select;
      // upper bits 00 or 01 are the only defined ranges
      gain_code_valid_o <= !pressure_gain_select[5];
      bridge_current_ua_o <= next_current_ua;
      // one filtered word per completed block
      // both channels never finish together: one sample per clock at most
      result_valid_o <= avg_valid[0] | avg_valid[1];
      result_is_temp_o <= avg_valid[1] & ~avg_valid[0];
      result_data_o <= avg_valid[0] ? avg_data[15:0] : avg_data[31:16];
    end
  end
endmodule // safr_regs_top
`default_nettype wire

// file: common/safr_regs.vh
`ifndef SAFR_REGS_VH
`define SAFR_REGS_VH
// =====================================================================
// register offsets on the serial register port
`define SAFR_ADDR_CONFIG 8'h00
`define SAFR_ADDR_FLAGS 8'h02
`define SAFR_ADDR_GAIN 8'h04
`define SAFR_ADDR_CURRENT 8'h05
`define SAFR_ADDR_IENABLE 8'h06
`define SAFR_ADDR_RAW_P 8'h08
`define SAFR_ADDR_RAW_T 8'h0A
// =====================================================================
// reset values
`define SAFR_CONFIG_RST 16'h0000
`define SAFR_GAIN_RST 6'h00
`define SAFR_CURRENT_RST 3'h0
`define SAFR_IENABLE_RST 10'h3FF
// =====================================================================
// configuration field positions
`define SAFR_CFG_ALERT_MODE_HI 3
`define SAFR_CFG_ALERT_MODE_LO 1
`define SAFR_CFG_SHUTDOWN 7
`define SAFR_CFG_AVG_HI 12
`define SAFR_CFG_AVG_LO 10
`define SAFR_CFG_P_BYPASS 13
`define SAFR_CFG_T_BYPASS 14
`define SAFR_CFG_MEM_DISABLE 15
`define SAFR_ALERT_MODE_IRQ 3'h0
// =====================================================================
// flag positions
`define SAFR_FLG_P_READY 8
`define SAFR_FLG_T_READY 9
`define SAFR_FLG_THERM_FAULT 10
`define SAFR_FLG_DRIVE_FAULT 11
`define SAFR_FLG_W 12
`define SAFR_IEN_W 10
// =====================================================================
// analog output source codes
`define SAFR_OUT_CAL 2'h0
`define SAFR_OUT_RAW_P 2'h1
`define SAFR_OUT_RAW_T 2'h2
`endif

// file: logic/safr_avg.v
`default_nettype none
// =====================================================================
// block averager: sums 2**log2n samples, emits sum >>> log2n
module safr_avg #(
  parameter W = 16,
  parameter LMAX = 7
) (
  input wire core_clk_i,
  input wire nrst_i,
  input wire ce_i,
  input wire restart_i,
  input wire [2:0] log2n_i,
  input wire in_valid_i,
  input wire [W-1:0] in_data_i,
  output reg out_valid_o,
  output reg [W-1:0] out_data_o
);
  reg signed [W+LMAX-1:0] acc;
  reg [LMAX-1:0] cnt;
  wire signed [W+LMAX-1:0] sample_ext = {{LMAX{in_data_i[W-1]}}, in_data_i};
  wire signed [W+LMAX-1:0] total = acc + sample_ext;
  wire [LMAX-1:0] last = (({{(LMAX-1){1'b0}}, 1'b1}) << log2n_i) - {{(LMAX-1){1'b0}}, 1'b1};
  wire signed [W+LMAX-1:0] shifted = total >>> log2n_i;
  // =====================================================================
  // accumulate, then truncate by right shift and restart
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc <= {(W+LMAX){1'b0}};
      cnt <= {LMAX{1'b0}};
      out_valid_o <= 1'b0;
      out_data_o <= {W{1'b0}};
    end else if (ce_i) begin
      out_valid_o <= 1'b0;
      if (restart_i) begin
        acc <= {(W+LMAX){1'b0}};
        cnt <= {LMAX{1'b0}};
      end else if (in_valid_i) begin
        if (cnt == last) begin
          acc <= {(W+LMAX){1'b0}};
          cnt <= {LMAX{1'b0}};
          out_valid_o <= 1'b1;
          out_data_o <= shifted[W-1:0];
        end else begin
          acc <= total;
          cnt <= cnt + {{(LMAX-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // safr_avg
`default_nettype wire

// file: dv/safr_asserts.sv
`include "safr_regs.vh"
`default_nettype none
// ====================================
// port-level checks of the register bank
module safr_asserts (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic drive_over_limit_i,
  input wire logic alert_n_o,
  input wire logic allow_pressure_conv_o,
  input wire logic allow_temp_conv_o,
  input wire logic [1:0] analog_out_src_o,
  input wire logic [7:0] avg_samples_o,
  input wire logic [5:0] front_end_amplifier_gain_o,
  input wire logic gain_code_valid_o,
  input wire logic [9:0] bridge_current_ua_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  AST_READ_ANSWER: assert property (reg_rd_i && ce_i |=> reg_rvalid_o)
    else $error("read not answered");
  AST_RDATA_HOLD: assert property (!reg_rvalid_o |-> $stable(reg_rdata_o))
    else $error("read data moved");
  AST_RAW_P_ONLY: assert property (
    analog_out_src_o == `SAFR_OUT_RAW_P |-> !allow_temp_conv_o)
    else $error("temperature allowed in raw pressure mode");
  AST_RAW_T_ONLY: assert property (
    analog_out_src_o == `SAFR_OUT_RAW_T |-> !allow_pressure_conv_o)
    else $error("pressure allowed in raw temperature mode");
  AST_AVG_DEPTH: assert property ($onehot(avg_samples_o) && avg_samples_o != 8'h02)
    else $error("illegal averaging depth");
  AST_CURRENT_CODE: assert property (bridge_current_ua_o inside {10'h0FA, 10'h12C,
    10'h190, 10'h1C2, 10'h1F4, 10'h226, 10'h28A, 10'h2EE}) else $error("bad current");
  AST_GAIN_FLAG: assert property (gain_code_valid_o == !front_end_amplifier_gain_o[5])
    else $error("gain valid flag wrong");
  AST_DRIVE_ALERT: assert property ((ce_i && drive_over_limit_i) [*5] |-> !alert_n_o)
    else $error("drive fault not on alert");
endmodule // safr_asserts
bind safr_regs_top safr_asserts u_chk (.core_clk_i, .nrst_i, .ce_i, .reg_rd_i, .reg_rdata_o,
  .reg_rvalid_o, .drive_over_limit_i, .alert_n_o, .allow_pressure_conv_o, .allow_temp_conv_o,
  .analog_out_src_o, .avg_samples_o, .front_end_amplifier_gain_o, .gain_code_valid_o,
  .bridge_current_ua_o);
`default_nettype wire

// file: dv/safr_host.sv
`default_nettype none
// ====================================
// host side of the register port
module safr_host (
  input wire logic core_clk_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  output logic [7:0] addr_o,
  output logic [15:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus before the first access
  initial begin
    addr_o = 8'hFF;
    wdata_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // one write; released lines show inverted leftovers, never the old value
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge core_clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // one read; a missing answer returns unknown so compares fail
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    int n;
    @(posedge core_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge core_clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (reg_rvalid_o !== 1'b1 && n < 4);
    d = (reg_rvalid_o === 1'b1) ? reg_rdata_o : 16'hXXXX;
  endtask
endmodule // safr_host
`default_nettype wire

// file: dv/tb.sv
`include "safr_regs.vh"
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0, nrst_i = 1'b0, ce_i = 1'b1;
  logic [7:0] reg_addr_i, pin_limit_cmp_i = 8'h00;
  logic [15:0] reg_wdata_i, reg_rdata_o, adc_data_i = 16'h0000, result_data_o, rv;
  logic reg_wr_i, reg_rd_i, reg_rvalid_o, adc_valid_i = 1'b0, adc_is_temp_i = 1'b0;
  logic drive_over_limit_i = 1'b0, bridge_imbalance_i = 1'b0, thermistor_over_limit_i = 1'b0;
  logic alert_n_o, shutdown_o, cal_memory_access_enable_o, allow_pressure_conv_o;
  logic allow_temp_conv_o, gain_code_valid_o, result_valid_o, result_is_temp_o;
  logic [1:0] analog_out_src_o;
  logic [7:0] avg_samples_o;
  logic [5:0] front_end_amplifier_gain_o;
  logic [9:0] bridge_current_ua_o;
  int num_errors = 0, samples_checked = 0, cycles = 0;
  safr_regs_top dut (.core_clk_i, .nrst_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .adc_valid_i, .adc_is_temp_i, .adc_data_i,
    .pin_limit_cmp_i, .drive_over_limit_i, .bridge_imbalance_i, .thermistor_over_limit_i,
    .alert_n_o, .shutdown_o, .cal_memory_access_enable_o, .allow_pressure_conv_o,
    .allow_temp_conv_o, .analog_out_src_o, .avg_samples_o, .front_end_amplifier_gain_o,
    .gain_code_valid_o, .bridge_current_ua_o, .result_valid_o, .result_is_temp_o,
    .result_data_o);
  safr_host host (.core_clk_i, .reg_rdata_o, .reg_rvalid_o, .addr_o(reg_addr_i),
    .wdata_o(reg_wdata_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i));
  // ====================================
  // clock and hang guard; the run needs well under a thousand cycles
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // one converter sample, strobe high for exactly one clock
  task automatic one_sample(input logic t, input logic [15:0] d);
    adc_valid_i <= 1'b1;
    adc_is_temp_i <= t;
    adc_data_i <= d;
    @(posedge core_clk_i);
    adc_valid_i <= 1'b0;
  endtask
  // ====================================
  // scenarios
  // power-on values, plus an unmapped read
  task automatic t_reset();
    host.rd(`SAFR_ADDR_CONFIG, rv);
    `CHK(rv, 16'h0000)
    host.rd(`SAFR_ADDR_IENABLE, rv);
    `CHK(rv, 16'h03FF)
    host.rd(8'h30, rv);
    `CHK(rv, 16'h0000)
    `CHK({cal_memory_access_enable_o, avg_samples_o}, 9'h101)
    $display("reset test done");
  endtask
  // reserved gain bits and every current code
  task automatic t_regs();
    logic [9:0] ua [8] = '{10'h0FA, 10'h12C, 10'h190, 10'h1C2, 10'h1F4, 10'h226, 10'h28A, 10'h2EE};
    host.wr(`SAFR_ADDR_GAIN, 16'h00FF);
    host.rd(`SAFR_ADDR_GAIN, rv);
    `CHK({rv, gain_code_valid_o}, 17'h007E)
    host.wr(`SAFR_ADDR_GAIN, 16'h0013);
    host.rd(`SAFR_ADDR_GAIN, rv);
    `CHK({front_end_amplifier_gain_o, gain_code_valid_o}, 7'h27)
    // a write while the clock enable is low must not land
    ce_i <= 1'b0;
    host.wr(`SAFR_ADDR_GAIN, 16'h0005);
    ce_i <= 1'b1;
    host.rd(`SAFR_ADDR_GAIN, rv);
    `CHK(rv, 16'h0013)
    for (int k = 0; k < 8; k++) begin
      host.wr(`SAFR_ADDR_CURRENT, 16'(k));
      ticks(3);
      `CHK(bridge_current_ua_o, ua[k])
    end
    $display("register test done");
  endtask
  // bypass, memory, shutdown and averaging fields reach the outputs
  task automatic t_cfg();
    logic [15:0] cw [4] = '{16'h8000, 16'h2000, 16'h4000, 16'h0080};
    logic [5:0] ex [4] = '{6'h0C, 6'h29, 6'h26, 6'h30};
    logic [5:0] mk [4] = '{6'h3F, 6'h3F, 6'h3F, 6'h3F};
    logic [5:0] outs;
    for (int k = 0; k < 4; k++) begin
      host.wr(`SAFR_ADDR_CONFIG, cw[k]);
      ticks(3);
      outs = {cal_memory_access_enable_o, shutdown_o, allow_pressure_conv_o, allow_temp_conv_o,
        analog_out_src_o};
      `CHK(outs & mk[k], ex[k])
    end
    for (int k = 0; k < 8; k++) begin
      host.wr(`SAFR_ADDR_CONFIG, 16'(k) << 10);
      ticks(3);
      `CHK(avg_samples_o, (k == 0 || k == 7) ? 8'h01 : 8'h01 << (k + 1))
    end
    $display("config test done");
  endtask
  // four pressure samples give one truncated mean, raw copy and ready flag
  task automatic t_avg();
    logic [15:0] s [4] = '{16'h0001, 16'h0002, 16'h0003, 16'h0005};
    int n;
    host.wr(`SAFR_ADDR_CONFIG, 16'h0400);
    ticks(2);
    for (int k = 0; k < 4; k++) begin
      adc_valid_i <= 1'b1;
      adc_data_i <= s[k];
      @(posedge core_clk_i);
    end
    adc_valid_i <= 1'b0;
    n = 0;
    while (result_valid_o !== 1'b1 && n < 8) begin
      @(posedge core_clk_i);
      n++;
    end
    `CHK({result_valid_o, result_is_temp_o, result_data_o}, 18'h20002)
    host.wr(`SAFR_ADDR_RAW_P, 16'hAAAA);
    host.rd(`SAFR_ADDR_RAW_P, rv);
    `CHK(rv, 16'h0002)
    host.rd(`SAFR_ADDR_FLAGS, rv);
    `CHK({rv, alert_n_o}, 17'h00200)
    // one temperature sample with filtering off, then dropped samples
    host.wr(`SAFR_ADDR_CONFIG, 16'h0000);
    ticks(2);
    one_sample(1'b1, 16'h8001);
    n = 0;
    while (result_valid_o !== 1'b1 && n < 8) begin
      @(posedge core_clk_i);
      n++;
    end
    `CHK({result_valid_o, result_is_temp_o, result_data_o}, 18'h38001)
    host.rd(`SAFR_ADDR_RAW_T, rv);
    `CHK(rv, 16'h8001)
    host.rd(`SAFR_ADDR_FLAGS, rv);
    `CHK(rv, 16'h0300)
    host.wr(`SAFR_ADDR_CONFIG, 16'h2000);
    ticks(2);
    one_sample(1'b1, 16'h7777);
    ticks(3);
    host.rd(`SAFR_ADDR_RAW_T, rv);
    `CHK(rv, 16'h8001)
    host.wr(`SAFR_ADDR_CONFIG, 16'h4000);
    ticks(2);
    one_sample(1'b0, 16'h1234);
    ticks(3);
    host.rd(`SAFR_ADDR_RAW_P, rv);
    `CHK(rv, 16'h0002)
    $display("averaging test done");
  endtask
  // masked ready flag, unmaskable sticky faults, write-back clear
  task automatic t_flags();
    host.wr(`SAFR_ADDR_IENABLE, 16'h0000);
    ticks(3);
    `CHK(alert_n_o, 1'b1)
    drive_over_limit_i <= 1'b1;
    thermistor_over_limit_i <= 1'b1;
    pin_limit_cmp_i <= 8'h01;
    ticks(6);
    `CHK(alert_n_o, 1'b0)
    drive_over_limit_i <= 1'b0;
    thermistor_over_limit_i <= 1'b0;
    pin_limit_cmp_i <= 8'h00;
    ticks(4);
    host.wr(`SAFR_ADDR_FLAGS, 16'hF000);
    host.rd(`SAFR_ADDR_FLAGS, rv);
    `CHK(rv, 16'h0F01)
    host.wr(`SAFR_ADDR_FLAGS, rv);
    host.rd(`SAFR_ADDR_FLAGS, rv);
    `CHK({rv, alert_n_o}, 17'h00001)
    // bridge imbalance alone raises the unmaskable drive fault
    bridge_imbalance_i <= 1'b1;
    ticks(6);
    bridge_imbalance_i <= 1'b0;
    host.rd(`SAFR_ADDR_FLAGS, rv);
    `CHK({rv, alert_n_o}, 17'h01000)
    host.wr(`SAFR_ADDR_FLAGS, rv);
    // enabled flag stays off the pin outside interrupt mode
    host.wr(`SAFR_ADDR_IENABLE, 16'h03FF);
    host.wr(`SAFR_ADDR_CONFIG, 16'h0002);
    pin_limit_cmp_i <= 8'h02;
    ticks(6);
    `CHK(alert_n_o, 1'b1)
    host.wr(`SAFR_ADDR_CONFIG, 16'h0000);
    ticks(3);
    `CHK(alert_n_o, 1'b0)
    pin_limit_cmp_i <= 8'h00;
    ticks(4);
    host.wr(`SAFR_ADDR_FLAGS, 16'h0002);
    ticks(3);
    `CHK(alert_n_o, 1'b1)
    $display("flag test done");
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_regs();
    t_cfg();
    t_avg();
    t_flags();
    close_out();
  end
endmodule // tb
`default_nettype wire
